// >>> core/panel_pkg.sv
// Shared constants for the front-panel configuration and status logic.
// Assumes a single 20 MHz system clock and switch contacts that close to ground.
package panel_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned WDOG_TIME_S     = 20;
    localparam int unsigned WDOG_CYCLES_DEF = WDOG_TIME_S * CLK_HZ;
    localparam int unsigned MS_PER_S        = 1000;
    localparam int unsigned MS_CYCLES_DEF   = CLK_HZ / MS_PER_S;
    localparam int unsigned SYNC_STAGES     = 2;

    // ************************************************************
    // Switch fields
    // ************************************************************
    localparam int unsigned BAUD_SW_W    = 3;
    localparam int unsigned BAUD_RATE_W  = 16;
    localparam int unsigned TXDELAY_W    = 8;
    localparam int unsigned CNT_W        = 32;
    localparam logic        SW_CLOSED    = 1'b0;
    localparam logic        SW_OPEN      = 1'b1;

    // ************************************************************
    // Baud select codes and rates
    // ************************************************************
    localparam logic [BAUD_SW_W-1:0] BAUD_CODE_150   = 3'h0;
    localparam logic [BAUD_SW_W-1:0] BAUD_CODE_600   = 3'h1;
    localparam logic [BAUD_SW_W-1:0] BAUD_CODE_1200  = 3'h2;
    localparam logic [BAUD_SW_W-1:0] BAUD_CODE_2400  = 3'h3;
    localparam logic [BAUD_SW_W-1:0] BAUD_CODE_4800  = 3'h4;
    localparam logic [BAUD_SW_W-1:0] BAUD_CODE_9600  = 3'h5;
    localparam logic [BAUD_SW_W-1:0] BAUD_CODE_19200 = 3'h6;
    localparam logic [BAUD_SW_W-1:0] BAUD_CODE_38400 = 3'h7;
    localparam logic [BAUD_SW_W-1:0] BAUD_CODE_RESET = BAUD_CODE_9600;

    localparam logic [BAUD_RATE_W-1:0] BAUD_150   = 16'h0096;
    localparam logic [BAUD_RATE_W-1:0] BAUD_600   = 16'h0258;
    localparam logic [BAUD_RATE_W-1:0] BAUD_1200  = 16'h04b0;
    localparam logic [BAUD_RATE_W-1:0] BAUD_2400  = 16'h0960;
    localparam logic [BAUD_RATE_W-1:0] BAUD_4800  = 16'h12c0;
    localparam logic [BAUD_RATE_W-1:0] BAUD_9600  = 16'h2580;
    localparam logic [BAUD_RATE_W-1:0] BAUD_19200 = 16'h4b00;
    localparam logic [BAUD_RATE_W-1:0] BAUD_38400 = 16'h9600;

    // ************************************************************
    // Transmit sequencing states
    // ************************************************************
    typedef enum logic [3:0] {
        TX_IDLE  = 4'b0001,
        TX_KEYUP = 4'b0010,
        TX_SEND  = 4'b0100,
        TX_TRIP  = 4'b1000
    } tx_state_t;

endpackage

// >>> core/pin_sync.sv
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes the inputs are slow levels; multi-bit groups may skew by one cycle.
`timescale 1ns/1ns
module pin_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_reset,
    // Levels
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;

    // First stage is read only by the second
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            meta_q <= '1;
            o_sync <= '1;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule

// >>> core/panel_config_status_logic.sv
// Front-panel switch decoding, status indicators and transmit watchdog.
// Assumes switch, busy and firmware-write inputs as described on the ports;
// the key request and key-up delay come from logic on the same clock.
`timescale 1ns/1ns
module panel_config_status_logic #(
    parameter int unsigned WDOG_CYCLES = panel_pkg::WDOG_CYCLES_DEF,
    parameter int unsigned MS_CYCLES   = panel_pkg::MS_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic                                 i_sys_clk,
    input  wire logic                                 i_reset,
    // Switch pins, closed = low
    input  wire logic [panel_pkg::BAUD_SW_W-1:0]      i_baud_sw,
    input  wire logic                                 i_bank_sw,
    // Modem and firmware
    input  wire logic                                 i_channel_busy,
    input  wire logic                                 i_key_request,
    input  wire logic [panel_pkg::TXDELAY_W-1:0]      i_txdelay_ms,
    input  wire logic                                 i_link_connected_set,
    input  wire logic                                 i_pending_packet_set,
    // Configuration outputs
    output logic      [panel_pkg::BAUD_SW_W-1:0]      o_baud_code,
    output logic      [panel_pkg::BAUD_RATE_W-1:0]    o_baud_rate,
    output logic                                      o_firmware_bank_bit,
    // Transmit control
    output logic                                      o_tx_key,
    output logic                                      o_data_enable,
    output logic                                      o_watchdog_tripped,
    // Indicators
    output logic                                      o_tx_led,
    output logic                                      o_busy_led,
    output logic                                      o_link_connected_led,
    output logic                                      o_pending_packet_led
);
    import panel_pkg::*;

    localparam int unsigned SYNC_W = BAUD_SW_W + 2;

    // ************************************************************
    // Decoding
    // ************************************************************
    function automatic logic [BAUD_RATE_W-1:0] baud_of(input logic [BAUD_SW_W-1:0] code);
        logic [BAUD_RATE_W-1:0] rate;
        rate = BAUD_9600;
        case (code)
            BAUD_CODE_150:   rate = BAUD_150;
            BAUD_CODE_600:   rate = BAUD_600;
            BAUD_CODE_1200:  rate = BAUD_1200;
            BAUD_CODE_2400:  rate = BAUD_2400;
            BAUD_CODE_4800:  rate = BAUD_4800;
            BAUD_CODE_9600:  rate = BAUD_9600;
            BAUD_CODE_19200: rate = BAUD_19200;
            BAUD_CODE_38400: rate = BAUD_38400;
            default:         rate = BAUD_9600;
        endcase
        return rate;
    endfunction

    // ************************************************************
    // Pin synchronisation
    // ************************************************************
    logic [SYNC_W-1:0] pins_sync;
    logic [BAUD_SW_W-1:0] baud_sync;
    logic              bank_sync;
    logic              busy_sync;

    pin_sync #(
        .WIDTH(SYNC_W)
    ) u_pin_sync (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_async   ({i_baud_sw, i_bank_sw, i_channel_busy}),
        .o_sync    (pins_sync)
    );

    // Synchroniser resets to all ones, which would flash a busy lamp and the top
    // baud code; its users wait until real pin levels have come through
    logic [SYNC_STAGES-1:0] fill_q;
    logic                   sync_ready;

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            fill_q <= '0;
        end else begin
            fill_q <= {fill_q[SYNC_STAGES-2:0], 1'b1};
        end
    end

    assign sync_ready = fill_q[SYNC_STAGES-1];
    assign baud_sync  = pins_sync[SYNC_W-1:2];
    assign bank_sync  = pins_sync[1];
    assign busy_sync  = pins_sync[0] && sync_ready;

    // ************************************************************
    // Configuration registers
    // ************************************************************
    // Contact level used as is; no inversion anywhere
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_baud_code         <= BAUD_CODE_RESET;
            o_baud_rate         <= BAUD_9600;
            o_firmware_bank_bit <= SW_OPEN;
        end else if (sync_ready) begin
            o_baud_code         <= baud_sync;
            o_baud_rate         <= baud_of(baud_sync);
            o_firmware_bank_bit <= bank_sync;
        end
    end

    // Firmware-owned indicators and the channel-busy lamp
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_link_connected_led <= 1'b0;
            o_pending_packet_led <= 1'b0;
            o_busy_led           <= 1'b0;
        end else begin
            o_link_connected_led <= i_link_connected_set;
            o_pending_packet_led <= i_pending_packet_set;
            o_busy_led           <= busy_sync;
        end
    end

    // ************************************************************
    // Transmit sequencing
    // ************************************************************
    tx_state_t         state_q;
    tx_state_t         state_d;
    logic [CNT_W-1:0]  wd_cnt_q;
    logic [CNT_W-1:0]  ms_cnt_q;
    logic [TXDELAY_W-1:0] delay_ms_q;
    logic              wd_expired;
    logic              delay_done;

    assign wd_expired = (wd_cnt_q >= CNT_W'(WDOG_CYCLES - 1));
    assign delay_done = (delay_ms_q >= i_txdelay_ms);

    // Busy drops keying at once; deferring here would stomp on another station
    always_comb begin
        state_d = state_q;
        case (state_q)
            TX_IDLE: begin
                // Channel state unknown until the synchroniser has filled
                if (i_key_request && !busy_sync && sync_ready) begin
                    state_d = TX_KEYUP;
                end
            end
            TX_KEYUP: begin
                if (!i_key_request || busy_sync) begin
                    state_d = TX_IDLE;
                end else if (wd_expired) begin
                    state_d = TX_TRIP;
                end else if (delay_done) begin
                    state_d = TX_SEND;
                end
            end
            TX_SEND: begin
                if (!i_key_request || busy_sync) begin
                    state_d = TX_IDLE;
                end else if (wd_expired) begin
                    state_d = TX_TRIP;
                end
            end
            TX_TRIP: begin
                if (!i_key_request) begin
                    state_d = TX_IDLE;
                end
            end
            default: state_d = TX_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            state_q <= TX_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Watchdog runs from key-up until release or a return to idle, not only while data is enabled
    always_ff @(posedge i_sys_clk) begin
        if (i_reset || !i_key_request || state_q == TX_IDLE) begin
            wd_cnt_q <= '0;
        end else if (!wd_expired) begin
            wd_cnt_q <= wd_cnt_q + CNT_W'(1);
        end
    end

    // Key-up delay in millisecond steps
    always_ff @(posedge i_sys_clk) begin
        if (i_reset || state_q != TX_KEYUP) begin
            ms_cnt_q   <= '0;
            delay_ms_q <= '0;
        end else if (ms_cnt_q >= CNT_W'(MS_CYCLES - 1)) begin
            ms_cnt_q   <= '0;
            if (!delay_done) begin
                delay_ms_q <= delay_ms_q + TXDELAY_W'(1);
            end
        end else begin
            ms_cnt_q <= ms_cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_tx_key           <= 1'b0;
            o_data_enable      <= 1'b0;
            o_tx_led           <= 1'b0;
            o_watchdog_tripped <= 1'b0;
        end else begin
            o_tx_key           <= (state_d == TX_KEYUP) || (state_d == TX_SEND);
            o_data_enable      <= (state_d == TX_SEND);
            o_tx_led           <= (state_d != TX_IDLE);
            o_watchdog_tripped <= (state_d == TX_TRIP);
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);

    logic [2:0] age_q;
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            age_q <= '0;
        end else if (age_q != 3'h7) begin
            age_q <= age_q + 3'h1;
        end
    end

    chk_switch_level: assert property (age_q == 3'h7 |-> o_baud_code == $past(i_baud_sw, 3))
        else $error("baud code does not follow switch level");
    chk_baud_low: assert property (o_baud_code == BAUD_CODE_600 |-> o_baud_rate == BAUD_600)
        else $error("code 001 not 600 baud");
    chk_baud_default: assert property ($fell(i_reset) |-> o_baud_rate == BAUD_9600)
        else $error("reset baud rate not 9600");
    chk_baud_top: assert property (o_baud_code == BAUD_CODE_38400 |-> o_baud_rate == BAUD_38400)
        else $error("code 111 not 38400 baud");
    chk_baud_fill: assert property (o_baud_code == BAUD_CODE_19200 |-> o_baud_rate == BAUD_19200)
        else $error("code 110 not 19200 baud");
    chk_bank_bit: assert property (age_q == 3'h7 |-> o_firmware_bank_bit == $past(i_bank_sw, 3))
        else $error("bank bit does not follow switch 4");
    chk_wdog_cut: assert property (wd_expired && i_key_request && !busy_sync && state_q != TX_IDLE
                                   |=> !o_tx_key && o_tx_led && o_watchdog_tripped)
        else $error("watchdog did not cut keying with lamp lit");
    chk_wdog_restart: assert property (!i_key_request |=> wd_cnt_q == '0)
        else $error("watchdog not restarted on release");
    chk_busy_block: assert property (busy_sync |=> !o_tx_key && o_busy_led)
        else $error("keyed while channel busy");
    chk_led_follow: assert property (##1 o_pending_packet_led == $past(i_pending_packet_set))
        else $error("pending lamp does not follow write");
    chk_delay_first: assert property ($rose(o_tx_key) && i_txdelay_ms != '0 |-> !o_data_enable)
        else $error("data enabled before key-up delay");

    cov_tripped: cover property (o_watchdog_tripped);
    cov_sending: cover property ($rose(o_data_enable));
    cov_busy_drop: cover property (o_tx_key ##1 busy_sync);
endmodule

// >>> tb/radio_partner.sv
// Behavioural radio: a carrier detector and a keyed transmitter.
// Assumes the bench commands the carrier and that keying arrives on the system clock.
`timescale 1ns/1ns
module radio_partner #(
    parameter int unsigned SWITCH_CYCLES = 8
) (
    // Clock
    input  wire logic i_sys_clk,
    // Control
    input  wire logic i_tx_key,
    input  wire logic i_busy_cmd,
    // Status
    output logic      o_channel_busy,
    output logic      o_rf_on
);
    int unsigned sw_cnt_q;

    // Carrier detect follows the commanded channel state
    assign o_channel_busy = i_busy_cmd;

    // Receive/transmit turnaround, bounded and short
    always_ff @(posedge i_sys_clk) begin
        if (!i_tx_key) begin
            sw_cnt_q <= 0;
            o_rf_on  <= 1'b0;
        end else if (sw_cnt_q < SWITCH_CYCLES) begin
            sw_cnt_q <= sw_cnt_q + 1;
        end else begin
            o_rf_on <= 1'b1;
        end
    end
endmodule

// >>> tb/panel_config_status_logic_tb.sv
// Self-checking bench for the front-panel configuration and status logic.
// Assumes shortened watchdog and millisecond counts; inputs change on falling edges.
`timescale 1ns/1ns
module panel_config_status_logic_tb;
    import panel_pkg::*;
    localparam int unsigned WDOG = 64;
    localparam int unsigned MSC  = 4;
    localparam logic [26:0] M_ALL  = 27'h7ffffff;
    localparam logic [26:0] M_NODE = 27'h7ffffdf;
    typedef struct { logic [26:0] e; logic [26:0] m; } note_t;

    logic i_sys_clk = 1'b0, i_reset = 1'b1, i_bank_sw = 1'b1, i_busy_cmd = 1'b0;
    logic i_channel_busy, i_key_request = 1'b0, i_link_connected_set = 1'b0, i_pending_packet_set = 1'b0;
    logic [2:0] i_baud_sw = 3'h5;
    logic [7:0] i_txdelay_ms = 8'h00;
    logic [2:0] o_baud_code;
    logic [15:0] o_baud_rate;
    logic o_firmware_bank_bit, o_tx_key, o_data_enable, o_watchdog_tripped;
    logic o_tx_led, o_busy_led, o_link_connected_led, o_pending_packet_led, rf_on;
    logic [26:0] obs;
    logic [15:0] rate_tab [8] = '{BAUD_150, BAUD_600, BAUD_1200, BAUD_2400,
                                  BAUD_4800, BAUD_9600, BAUD_19200, BAUD_38400};
    note_t notes[$];
    event sample_ev;
    int error_cnt = 0, checks = 0, cnt;
    logic [31:0] rnd = 32'h99a7;

    always #25 i_sys_clk = ~i_sys_clk;
    assign obs = {o_baud_code, o_baud_rate, o_firmware_bank_bit, o_tx_key, o_data_enable,
                  o_watchdog_tripped, o_tx_led, o_busy_led, o_link_connected_led, o_pending_packet_led};

    panel_config_status_logic #(.WDOG_CYCLES(WDOG), .MS_CYCLES(MSC)) panel_config_status_logic_inst (
        .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_baud_sw(i_baud_sw), .i_bank_sw(i_bank_sw),
        .i_channel_busy(i_channel_busy), .i_key_request(i_key_request), .i_txdelay_ms(i_txdelay_ms),
        .i_link_connected_set(i_link_connected_set), .i_pending_packet_set(i_pending_packet_set),
        .o_baud_code(o_baud_code), .o_baud_rate(o_baud_rate), .o_firmware_bank_bit(o_firmware_bank_bit),
        .o_tx_key(o_tx_key), .o_data_enable(o_data_enable), .o_watchdog_tripped(o_watchdog_tripped),
        .o_tx_led(o_tx_led), .o_busy_led(o_busy_led), .o_link_connected_led(o_link_connected_led),
        .o_pending_packet_led(o_pending_packet_led));

    // One millisecond turnaround, well inside the key-up delay used below
    radio_partner #(.SWITCH_CYCLES(MSC)) radio_partner_inst (
        .i_sys_clk(i_sys_clk), .i_tx_key(o_tx_key), .i_busy_cmd(i_busy_cmd),
        .o_channel_busy(i_channel_busy), .o_rf_on(rf_on));

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [26:0] ev(input logic [2:0] c, input logic [7:0] f);
        return {c, rate_tab[c], f};
    endfunction

    task automatic check(input logic [26:0] seen, input logic [26:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic note(input logic [26:0] e, input logic [26:0] m);
        note_t n;
        n.e = e;
        n.m = m;
        notes.push_back(n);
        -> sample_ev;
        @(negedge i_sys_clk);
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watcher: oldest note against the settled outputs
    always @(sample_ev) begin
        note_t n;
        n = notes.pop_front();
        check(obs & n.m, n.e & n.m);
    end

    initial begin
        repeat (20000) @(posedge i_sys_clk);
        error_cnt++;
        print_verdict();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        step(5);
        note(ev(3'h5, 8'h80), M_ALL);
        i_reset = 1'b0;
        for (int c = 0; c < 8; c++) begin
            i_baud_sw = 3'(c);
            step(4);
            note(ev(3'(c), 8'h80), M_ALL);
        end
        for (int k = 0; k < 8; k++) begin
            rnd = xs(rnd);
            {i_bank_sw, i_link_connected_set, i_pending_packet_set} = rnd[2:0];
            step(4);
            note(ev(3'h7, {rnd[2], 5'h00, rnd[1:0]}), M_ALL);
        end
        i_link_connected_set = 1'b0;
        i_pending_packet_set = 1'b0;
        i_bank_sw = 1'b1;
        i_txdelay_ms = 8'h02;
        step(4);
        // Keyed, indicator lit, then delay counted before data
        i_key_request = 1'b1;
        step(2);
        note(ev(3'h7, 8'hc8), M_NODE);
        cnt = 0;
        while (o_data_enable !== 1'b1 && cnt < 40) begin
            step(1);
            cnt++;
        end
        // Key was already showing two cycles before the first poll
        check({26'h0, cnt + 2 >= 2 * MSC && cnt + 2 <= 2 * MSC + 2}, 27'h1);
        check({26'h0, rf_on}, 27'h1);
        cnt = 0;
        while (o_watchdog_tripped !== 1'b1 && cnt < 100) begin
            step(1);
            cnt++;
        end
        check({26'h0, cnt > 40 && cnt < 70}, 27'h1);
        note(ev(3'h7, 8'h98), M_ALL);
        i_key_request = 1'b0;
        step(2);
        note(ev(3'h7, 8'h80), M_ALL);
        // Fresh request gets the full interval again
        i_key_request = 1'b1;
        step(50);
        note(ev(3'h7, 8'hc8), M_NODE);
        // Carrier appears mid-transmission: keying drops
        i_busy_cmd = 1'b1;
        step(4);
        note(ev(3'h7, 8'h84), M_ALL);
        step(20);
        note(ev(3'h7, 8'h84), M_ALL);
        i_busy_cmd = 1'b0;
        i_key_request = 1'b0;
        step(5);
        // Zero delay: data right after keying
        i_txdelay_ms = 8'h00;
        i_key_request = 1'b1;
        step(3);
        note(ev(3'h7, 8'he8), M_ALL);
        i_key_request = 1'b0;
        step(3);
        print_verdict();
    end
endmodule
